//--- core/apc_control.sv
// Purpose: power-down, sync, calibration and settling control of a converter
// Assumes: all pins asynchronous to ref_clk; one master clock
// Notes: analog blocks are steered by level outputs only
`timescale 1ns/1ns
`default_nettype none

module apc_control
  import apc_pkg::*;
#(
  parameter int unsigned PDWN_LIMIT = PDWN_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic sync_powerdown_n,
  input wire logic [1:0] modeSel,
  input wire logic formatSel,
  input wire logic [23:0] calOffsetIn,
  output logic data_ready_n,
  output logic serial_out_hold_low,
  output logic inputShort,
  output logic poweredDown,
  output logic convStrobe,
  output logic modulator_rate,
  output logic [7:0] osrOut,
  output logic [23:0] offsetValue,
  output logic [1:0] activeMode,
  output logic filterReset
);

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  logic syncMeta_r;
  logic syncPin_r;
  logic [1:0] modeMeta_r, modeSync_r;
  logic fmtMeta_r, fmtSync_r;

  // two stages each; pins are asynchronous to the master clock
  always_ff @(posedge ref_clk) begin
    syncMeta_r <= sync_powerdown_n;
    syncPin_r <= syncMeta_r;
    modeMeta_r <= modeSel;
    modeSync_r <= modeMeta_r;
    fmtMeta_r <= formatSel;
    fmtSync_r <= fmtMeta_r;
  end

  logic pinLow;
  assign pinLow = ~syncPin_r;

  // ---------------------------------------------------------------
  // mode debounce and filter configuration
  // ---------------------------------------------------------------
  apc_state_t state_r;
  apc_mode_t mode_r;
  logic [13:0] modeCnt_r;
  logic modeChange;
  apc_filt_cfg_t cfg;

  // a new mode must persist before it is acted on; the pin is ignored
  // in power-down so that no output moves there
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mode_r <= APC_MODE_HS;
      modeCnt_r <= MODE_CNT_RESET;
    end else if (state_r == ST_PDWN || modeSync_r == mode_r
                 || modeSync_r == 2'h3) begin
      modeCnt_r <= MODE_CNT_RESET;
    end else if (modeCnt_r == 14'(MODE_PERSIST_CYCLES - 1)) begin
      mode_r <= apc_mode_t'(modeSync_r);
      modeCnt_r <= MODE_CNT_RESET;
    end else begin
      modeCnt_r <= modeCnt_r + 14'h0001;
    end
  end

  assign modeChange = (modeSync_r != mode_r) && (modeSync_r != 2'h3)
    && (state_r != ST_PDWN)
    && (modeCnt_r == 14'(MODE_PERSIST_CYCLES - 1));

  // fast modes share ratio and settling; only HS uses the fast divider and short conversion
  always_comb begin
    if (mode_r == APC_MODE_HR) begin
      cfg.osr = OSR_HIRES;
      cfg.modDiv = MOD_DIV_SLOW;
      cfg.convLen = CONV_SLOW_CYCLES;
      cfg.settleConv = SETTLE_HIRES_CONV;
    end else begin
      cfg.osr = OSR_FAST;
      cfg.modDiv = (mode_r == APC_MODE_HS) ? MOD_DIV_FAST : MOD_DIV_SLOW;
      cfg.convLen = (mode_r == APC_MODE_HS) ? CONV_HS_CYCLES
                                            : CONV_SLOW_CYCLES;
      cfg.settleConv = SETTLE_FAST_CONV;
    end
  end

  // ---------------------------------------------------------------
  // control sequence
  // ---------------------------------------------------------------
  logic [19:0] lowCnt_r;
  logic [9:0] convCnt_r;
  logic [6:0] settleCnt_r;
  logic convEnd;

  assign convEnd = (convCnt_r == cfg.convLen - 10'h001);

  // length of the low level on the sync pin
  always_ff @(posedge ref_clk) begin
    if (rst || !pinLow) begin
      lowCnt_r <= PDWN_CNT_RESET;
    end else if (lowCnt_r != 20'(PDWN_LIMIT - 1)) begin
      lowCnt_r <= lowCnt_r + 20'h00001;
    end
  end

  // state walk: run, sync, power-down, calibrate, settle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_r <= ST_RUN;
    end else begin
      unique case (state_r)
        ST_RUN: begin
          if (pinLow) state_r <= ST_SYNC;
        end
        ST_SYNC: begin
          if (pinLow && lowCnt_r == 20'(PDWN_LIMIT - 1)) begin
            state_r <= ST_PDWN;
          end else if (!pinLow) begin
            state_r <= ST_SETTLE;
          end
        end
        ST_PDWN: begin
          if (!pinLow) state_r <= ST_CAL;
        end
        ST_CAL: begin
          if (pinLow) state_r <= ST_SYNC;
          else if (convCnt_r == CAL_CYCLES - 10'h001) state_r <= ST_SETTLE;
        end
        ST_SETTLE: begin
          if (pinLow) state_r <= ST_SYNC;
          else if (convEnd && settleCnt_r == cfg.settleConv - 7'h01) begin
            state_r <= ST_RUN;
          end
        end
      endcase
    end
  end

  // conversion timer, cleared while stopped
  always_ff @(posedge ref_clk) begin
    if (rst || pinLow || state_r == ST_PDWN || state_r == ST_SYNC) begin
      convCnt_r <= CONV_CNT_RESET;
    end else if (state_r == ST_CAL) begin
      // restart at calibration end so settling counts whole conversions
      if (convCnt_r == CAL_CYCLES - 10'h001) begin
        convCnt_r <= CONV_CNT_RESET;
      end else begin
        convCnt_r <= convCnt_r + 10'h001;
      end
    end else if (convEnd) begin
      convCnt_r <= CONV_CNT_RESET;
    end else begin
      convCnt_r <= convCnt_r + 10'h001;
    end
  end

  // settling counts whole conversions
  always_ff @(posedge ref_clk) begin
    if (rst || state_r != ST_SETTLE || pinLow) begin
      settleCnt_r <= SETTLE_CNT_RESET;
    end else if (convEnd) begin
      settleCnt_r <= settleCnt_r + 7'h01;
    end
  end

  // offset store: cleared on mode change, loaded after calibration
  always_ff @(posedge ref_clk) begin
    if (rst || modeChange) begin
      offsetValue <= OFFSET_RESET;
    end else if (state_r == ST_CAL && !pinLow
                 && convCnt_r == CAL_CYCLES - 10'h001) begin
      offsetValue <= calOffsetIn;
    end
  end

  // ---------------------------------------------------------------
  // registered outputs
  // ---------------------------------------------------------------
  logic [2:0] divCnt_r;
  logic isRun;
  assign isRun = (state_r == ST_RUN) && !pinLow;

  // modulator clock divider, stopped in power-down
  always_ff @(posedge ref_clk) begin
    if (rst || state_r == ST_PDWN || state_r == ST_SYNC) begin
      divCnt_r <= 3'h0;
      modulator_rate <= 1'b0;
    end else if (divCnt_r == (cfg.modDiv >> 1) - 3'h1) begin
      divCnt_r <= 3'h0;
      modulator_rate <= ~modulator_rate;
    end else begin
      divCnt_r <= divCnt_r + 3'h1;
    end
  end

  // status levels; all constant during power-down
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      data_ready_n <= 1'b1;
      serial_out_hold_low <= 1'b1;
      inputShort <= 1'b0;
      poweredDown <= 1'b0;
      convStrobe <= 1'b0;
      osrOut <= OSR_FAST;
      activeMode <= 2'h0;
      filterReset <= 1'b1;
    end else begin
      // spi ready stays high until valid data
      data_ready_n <= !(isRun && !fmtSync_r && convEnd);
      serial_out_hold_low <= !isRun || !fmtSync_r;
      inputShort <= (state_r == ST_CAL) && !pinLow;
      poweredDown <= (state_r == ST_PDWN);
      convStrobe <= isRun && convEnd;
      osrOut <= cfg.osr;
      activeMode <= mode_r;
      filterReset <= pinLow || state_r == ST_PDWN;
    end
  end

endmodule

`default_nettype wire

//--- inc/apc_pkg.sv
// Purpose: shared constants and types for the power-down/calibration control
// Assumes: master clock ref_clk at 20 MHz
// Notes: counts are in master clock periods, settling counts in conversions
package apc_pkg;

  localparam int unsigned PDWN_CYCLES = 524288; // 2^19 periods
  localparam int unsigned MODE_PERSIST_CYCLES = 12288;
  localparam logic [9:0] CONV_HS_CYCLES = 10'h100; // 256 periods
  localparam logic [9:0] CONV_SLOW_CYCLES = 10'h200; // 512 periods
  localparam logic [7:0] OSR_FAST = 8'h40; // 64
  localparam logic [7:0] OSR_HIRES = 8'h80; // 128
  localparam logic [2:0] MOD_DIV_FAST = 3'h2; // CLK/2
  localparam logic [2:0] MOD_DIV_SLOW = 3'h4; // CLK/4
  localparam logic [6:0] SETTLE_FAST_CONV = 7'h4C; // 76 conversions
  localparam logic [6:0] SETTLE_HIRES_CONV = 7'h4E; // 78 conversions
  localparam logic [23:0] OFFSET_RESET = 24'h000000;
  localparam logic [19:0] PDWN_CNT_RESET = 20'h00000;
  localparam logic [13:0] MODE_CNT_RESET = 14'h0000;
  localparam logic [9:0] CONV_CNT_RESET = 10'h000;
  localparam logic [6:0] SETTLE_CNT_RESET = 7'h00;
  localparam logic [9:0] CAL_CYCLES = 10'h200; // one slow conversion

  typedef enum logic [1:0] {
    APC_MODE_HS = 2'h0,
    APC_MODE_HR = 2'h1,
    APC_MODE_LP = 2'h2
  } apc_mode_t;

  typedef enum logic [4:0] {
    ST_RUN = 5'h01,
    ST_SYNC = 5'h02,
    ST_PDWN = 5'h04,
    ST_CAL = 5'h08,
    ST_SETTLE = 5'h10
  } apc_state_t;

  // filter setup derived from the active mode
  typedef struct packed {
    logic [7:0] osr;
    logic [2:0] modDiv;
    logic [9:0] convLen;
    logic [6:0] settleConv;
  } apc_filt_cfg_t;

endpackage

//--- verif/apc_control_monitor.sv
// Purpose: port checker for apc_control
// Assumes: one clock, sync reset
// Notes: bound from the bench top file
`timescale 1ns/1ns
`default_nettype none
module apc_control_monitor
  import apc_pkg::*;
#(
  parameter int unsigned PDWN_LIMIT = PDWN_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic sync_powerdown_n,
  input wire logic data_ready_n,
  input wire logic serial_out_hold_low,
  input wire logic inputShort,
  input wire logic poweredDown,
  input wire logic convStrobe,
  input wire logic modulator_rate,
  input wire logic [7:0] osrOut,
  input wire logic [1:0] activeMode,
  input wire logic filterReset
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // helper: cycles the pin has stayed low, saturating
  logic [19:0] lowRun_r;
  always_ff @(posedge ref_clk) begin
    if (rst || sync_powerdown_n) begin
      lowRun_r <= 20'h00000;
    end else if (lowRun_r != 20'hFFFFF) begin
      lowRun_r <= lowRun_r + 20'h00001;
    end
  end
  pdwn_quiet_a: assert property (
    poweredDown |-> !convStrobe && data_ready_n && !modulator_rate)
    else $error("output active in power-down");
  pdwn_entry_a: assert property (
    $rose(poweredDown) |-> !sync_powerdown_n && lowRun_r >= 20'(PDWN_LIMIT))
    else $error("power-down without long low");
  pdwn_static_a: assert property (
    poweredDown && $past(poweredDown) |-> $stable(activeMode)
    && $stable(osrOut) && $stable(serial_out_hold_low))
    else $error("output moved in power-down");
  cal_start_a: assert property (
    $fell(poweredDown) |-> ##[1:6] inputShort)
    else $error("no calibration after wake");
  cal_short_a: assert property (
    $rose(inputShort) |-> !poweredDown ##1 inputShort[*8])
    else $error("input short too brief");
  osr_mode_a: assert property (
    activeMode == $past(activeMode) && activeMode == $past(activeMode, 2)
    |-> osrOut == (activeMode == APC_MODE_HR ? OSR_HIRES : OSR_FAST))
    else $error("ratio does not match mode");
  rdy_pulse_a: assert property (
    !data_ready_n |-> convStrobe ##1 data_ready_n)
    else $error("ready pulse wrong");
  out_hold_a: assert property (
    inputShort || poweredDown |-> serial_out_hold_low)
    else $error("serial out released early");
  strobe_gap_a: assert property (
    convStrobe |=> !convStrobe[*8])
    else $error("strobes too close");
  sync_reset_a: assert property (
    $fell(sync_powerdown_n) |-> ##[1:5] filterReset)
    else $error("filter not reset on low pin");
  // main scenarios reached
  cover property ($rose(poweredDown));
  cover property ($fell(inputShort));
  cover property ($fell(data_ready_n));
endmodule
`default_nettype wire

//--- verif/apc_host_model.sv
// Purpose: host side driving the sync/power-down pin
// Assumes: bench requests a low level on holdLow
// Notes: pin moves only on a rising clock edge
`timescale 1ns/1ns
`default_nettype none
module apc_host_model (
  input wire logic ref_clk,
  input wire logic holdLow,
  output logic sync_powerdown_n
);
  // always driven, never floating; edge aligned release
  initial sync_powerdown_n = 1'b1;
  always @(posedge ref_clk) begin
    sync_powerdown_n <= !holdLow;
  end
endmodule
`default_nettype wire

//--- verif/apc_control_tb.sv
// Purpose: self-checking bench for apc_control
// Assumes: power-down threshold cut to 64 cycles
// Notes: settle and mode waits dominate run time
`timescale 1ns/1ns
`default_nettype none
module apc_control_tb;
  import apc_pkg::*;
  localparam int unsigned PDL = 64;
  typedef struct packed {
    logic [1:0] sel; logic [15:0] hold; logic [1:0] mode; logic [7:0] osr;
  } apc_row_t;
  logic ref_clk, rst, holdLow, sync_powerdown_n, formatSel, prev;
  logic [1:0] modeSel, activeMode;
  logic [23:0] calOffsetIn, offsetValue;
  logic data_ready_n, serial_out_hold_low, inputShort, poweredDown;
  logic convStrobe, modulator_rate, filterReset;
  logic [7:0] osrOut;
  int fail_count = 0, checks_done = 0, cycles = 0, n;
  // first two rows straddle the persistence count
  apc_row_t rows [6] = '{'{2'h2, 16'h2FF0, APC_MODE_HS, OSR_FAST},
    '{2'h2, 16'h0030, APC_MODE_LP, OSR_FAST},
    '{2'h1, 16'h3010, APC_MODE_HR, OSR_HIRES},
    '{2'h3, 16'h3010, APC_MODE_HR, OSR_HIRES},
    '{2'h0, 16'h3010, APC_MODE_HS, OSR_FAST},
    '{2'h2, 16'h0064, APC_MODE_HS, OSR_FAST}};
  apc_host_model apc_host_model_inst (.ref_clk(ref_clk), .holdLow(holdLow),
    .sync_powerdown_n(sync_powerdown_n));
  apc_control #(.PDWN_LIMIT(PDL)) apc_control_inst (.ref_clk(ref_clk),
    .rst(rst), .sync_powerdown_n(sync_powerdown_n), .modeSel(modeSel),
    .formatSel(formatSel), .calOffsetIn(calOffsetIn),
    .data_ready_n(data_ready_n), .serial_out_hold_low(serial_out_hold_low),
    .inputShort(inputShort), .poweredDown(poweredDown),
    .convStrobe(convStrobe), .modulator_rate(modulator_rate),
    .osrOut(osrOut), .offsetValue(offsetValue), .activeMode(activeMode),
    .filterReset(filterReset));
  // clock and hang guard
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  always @(negedge ref_clk) begin
    cycles++;
    if (cycles == 90000) begin
      fail_count++;
      $display("CHECK FAILED %0t timeout", $time);
      final_report();
    end
  end
  task automatic cyc(input int k);
    repeat (k) @(negedge ref_clk);
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] exp,
    input string msg);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask
  // cycles to the next conversion strobe, bounded
  task automatic waitStrobe(output int k, input int lim);
    k = 0;
    do begin
      cyc(1);
      k++;
    end while (convStrobe !== 1'b1 && k < lim);
  endtask
  task automatic final_report();
    if (fail_count == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    rst = 1'b1;
    holdLow = 1'b0;
    modeSel = 2'h0;
    formatSel = 1'b1;
    calOffsetIn = 24'h5A3C01;
    cyc(4);
    chk(24'({data_ready_n, serial_out_hold_low, poweredDown}), 24'h6, "rst");
    chk(24'(osrOut) + offsetValue, 24'h40, "rst values");
    rst = 1'b0;
    holdLow = 1'b1;
    cyc(8);
    chk(24'(filterReset), 24'h1, "no filter reset");
    holdLow = 1'b0;
    cyc(PDL + 8);
    chk(24'({poweredDown, inputShort}), 24'h0, "sync");
    chk(offsetValue, 24'h0, "sync offset");
    holdLow = 1'b1;
    cyc(PDL + 8);
    chk(24'(poweredDown), 24'h1, "no power-down");
    holdLow = 1'b0;
    cyc(6);
    chk(24'({poweredDown, inputShort}), 24'h1, "no calibration");
    n = 0;
    while (inputShort === 1'b1 && n < 600) begin
      cyc(1);
      n++;
    end
    chk(offsetValue, calOffsetIn, "offset not loaded");
    // a short pulse while settling restarts it but keeps the offset
    holdLow = 1'b1;
    cyc(8);
    holdLow = 1'b0;
    cyc(8);
    chk(offsetValue, calOffsetIn, "offset lost on sync");
    waitStrobe(n, 20000);
    chk(24'(n >= 19456 && n <= 19800), 24'h1, "settle time");
    cyc(2);
    chk(24'(serial_out_hold_low), 24'h0, "frame out held");
    n = 0;
    repeat (32) begin
      prev = modulator_rate;
      cyc(1);
      n += int'(!prev && modulator_rate);
    end
    chk(24'(n), 24'h10, "modulator rate");
    formatSel = 1'b0;
    waitStrobe(n, 300);
    waitStrobe(n, 300);
    chk(24'(n), 24'h100, "conversion length");
    chk(24'({data_ready_n, serial_out_hold_low}), 24'h1, "spi");
    foreach (rows[i]) begin
      modeSel = rows[i].sel;
      cyc(int'(rows[i].hold));
      chk(24'(activeMode), 24'(rows[i].mode), "mode");
      chk(24'(osrOut), 24'(rows[i].osr), "ratio");
      if (i > 0) chk(offsetValue, 24'h0, "offset kept");
    end
    // reset in mid-run returns every level to its idle value
    rst = 1'b1;
    cyc(4);
    chk(24'({data_ready_n, serial_out_hold_low, filterReset}), 24'h7, "rst2");
    chk(24'(activeMode) + 24'(osrOut) + offsetValue, 24'h40, "rst2 values");
    rst = 1'b0;
    cyc(4);
    chk(24'(filterReset), 24'h0, "filter reset after release");
    final_report();
  end
endmodule
bind apc_control apc_control_monitor #(.PDWN_LIMIT(PDWN_LIMIT))
  apc_control_monitor_inst (.ref_clk(ref_clk), .rst(rst),
  .sync_powerdown_n(sync_powerdown_n), .data_ready_n(data_ready_n),
  .serial_out_hold_low(serial_out_hold_low), .inputShort(inputShort),
  .poweredDown(poweredDown), .convStrobe(convStrobe),
  .modulator_rate(modulator_rate), .osrOut(osrOut),
  .activeMode(activeMode), .filterReset(filterReset));
`default_nettype wire
